// >>> core/mult_pkg.sv
// Constants for the pipelined 18x18 signed multiplier with an APB control port.
// Assumes a 32-bit APB bus on pclk; offsets below are byte addresses.
package mult_pkg;
  localparam int unsigned OPERAND_W = 18;
  localparam int unsigned PRODUCT_W = 36;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // Register byte offsets
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] PRODUCT_LO_OFFSET = 8'h04;
  localparam logic [7:0] PRODUCT_HI_OFFSET = 8'h08;
  localparam logic [7:0] CHAIN_OUT_OFFSET = 8'h0C;

  // Config field positions
  localparam int unsigned CFG_FIRST_REG_BIT = 0;
  localparam int unsigned CFG_SECOND_REG_BIT = 1;
  localparam int unsigned CFG_PRODUCT_REG_BIT = 2;
  localparam int unsigned CFG_CHAIN_SEL_BIT = 3;
  localparam int unsigned CFG_INV_CLK_BIT = 8;
  localparam int unsigned CFG_INV_CE_A_BIT = 9;
  localparam int unsigned CFG_INV_RST_A_BIT = 10;
  localparam int unsigned CFG_INV_CE_B_BIT = 11;
  localparam int unsigned CFG_INV_RST_B_BIT = 12;
  localparam int unsigned CFG_INV_CE_P_BIT = 13;
  localparam int unsigned CFG_INV_RST_P_BIT = 14;
  localparam logic [31:0] CONFIG_MASK = 32'h00007F0F;

  // Values after reset: all three registers bypassed, direct path, true polarity
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;
  localparam logic [17:0] OPERAND_RESET = 18'h00000;
  localparam logic [35:0] PRODUCT_RESET = 36'h000000000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage

// >>> core/pipe_stage.sv
// One optional pipeline register with clock enable and synchronous clear.
// Assumes enable and clear are already at true polarity and on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pipe_stage #(
  parameter int unsigned WIDTH = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic sync_clear,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (sync_clear) begin
      // Clear outranks the enable
      q <= '0; // RULE_12 RULE_14 RULE_16
    end else if (clk_en) begin
      q <= d; // RULE_11 RULE_13 RULE_15
    end
  end
endmodule
`default_nettype wire

// >>> core/signed_mult18_pipelined.sv
// Signed 18x18 multiplier with optional operand and product registers.
// Assumes operands and controls come from fabric logic on pclk; config over APB.
// Overview of operation
// RULE_01: First operand is 18-bit signed multiplicand.
// RULE_02: Direct select uses direct second operand.
// RULE_03: Chained select uses cascade input operand.
// RULE_04: Unregistered first operand flows combinationally through.
// RULE_05: Full 36-bit signed product, combinational unregistered.
// RULE_06: Product register updates on edge with controls.
// RULE_07: Both operands registered: product follows edges.
// RULE_08: One operand registered: mixed clocked/combinational product.
// RULE_09: Unregistered chain output follows selected operand.
// RULE_10: Registered chain output comes from second register.
// RULE_11: First register loads when enabled, not cleared.
// RULE_12: First register clear beats its enable.
// RULE_13: Second register loads selected operand when enabled.
// RULE_14: Second register clear beats its enable.
// RULE_15: Product register loads result when enabled.
// RULE_16: Product register clear beats its enable.
// RULE_17: Clock and six controls may be inverted; code inverts only the six controls, config bit 8 unused.
// RULE_18: Integrator avoids multiplier with wide neighbour memory.
// RULE_19: Upper 16 first-operand bits share memory routing.
// RULE_20: Upper 16 second-operand bits share memory routing.
// RULE_21: Each register inserted or bypassed independently.
// RULE_22: One clock, separate enables and clears.
// RULE_23: Chain output feeds neighbour block's chain input.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module signed_mult18_pipelined
  import mult_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [17:0] first_operand,
  input wire logic [17:0] second_operand,
  input wire logic [17:0] chain_operand_in,
  input wire logic first_operand_clock_enable,
  input wire logic first_operand_sync_reset,
  input wire logic second_operand_clock_enable,
  input wire logic second_operand_sync_reset,
  input wire logic product_clock_enable,
  input wire logic product_sync_reset,
  output logic [35:0] product,
  output logic [17:0] chain_operand_out
);
  logic [31:0] config_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] read_next;
  logic addr_hit;
  logic first_reg_on;
  logic second_reg_on;
  logic product_reg_on;
  logic chain_sel;
  logic ce_a;
  logic rst_a;
  logic ce_b;
  logic rst_b;
  logic ce_p;
  logic rst_p;
  logic [17:0] first_q;
  logic [17:0] second_q;
  logic [35:0] product_q;
  logic [17:0] first_value;
  logic [17:0] second_in;
  logic [17:0] second_value;
  logic signed [35:0] raw_product;

  assign first_reg_on = config_reg[CFG_FIRST_REG_BIT];
  assign second_reg_on = config_reg[CFG_SECOND_REG_BIT];
  assign product_reg_on = config_reg[CFG_PRODUCT_REG_BIT];
  assign chain_sel = config_reg[CFG_CHAIN_SEL_BIT];

  // Control polarity: a set config bit makes the pin active low
  assign ce_a = first_operand_clock_enable ^ config_reg[CFG_INV_CE_A_BIT]; // RULE_17
  assign rst_a = first_operand_sync_reset ^ config_reg[CFG_INV_RST_A_BIT]; // RULE_17
  assign ce_b = second_operand_clock_enable ^ config_reg[CFG_INV_CE_B_BIT]; // RULE_17
  assign rst_b = second_operand_sync_reset ^ config_reg[CFG_INV_RST_B_BIT]; // RULE_17
  assign ce_p = product_clock_enable ^ config_reg[CFG_INV_CE_P_BIT]; // RULE_17
  assign rst_p = product_sync_reset ^ config_reg[CFG_INV_RST_P_BIT]; // RULE_17

  // Second operand source select
  assign second_in = chain_sel ? chain_operand_in : second_operand; // RULE_02 RULE_03

  // All three stages share pclk, each with its own enable and clear
  pipe_stage #(.WIDTH(OPERAND_W)) first_stage ( // RULE_22
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(ce_a),
    .sync_clear(rst_a),
    .d(first_operand),
    .q(first_q)
  );

  pipe_stage #(.WIDTH(OPERAND_W)) second_stage (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(ce_b),
    .sync_clear(rst_b),
    .d(second_in),
    .q(second_q)
  );

  // Bypass muxes make each register optional in any combination
  assign first_value = first_reg_on ? first_q : first_operand; // RULE_04 RULE_21
  assign second_value = second_reg_on ? second_q : second_in; // RULE_21

  // Signed multiply at full precision
  assign raw_product = $signed(first_value) * $signed(second_value); // RULE_01 RULE_05

  pipe_stage #(.WIDTH(PRODUCT_W)) product_stage (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(ce_p),
    .sync_clear(rst_p),
    .d(raw_product),
    .q(product_q)
  );

  // With the product stage bypassed, the product tracks whichever operand
  // paths are registered or open, so it moves on edges, on inputs, or both
  assign product = product_reg_on ? product_q : raw_product; // RULE_06 RULE_07 RULE_08

  // Chain output is the multiplier's second input, registered or not
  assign chain_operand_out = second_value; // RULE_09 RULE_10 RULE_23

  // APB decode
  always_comb begin
    addr_hit = 1'b1;
    read_next = READ_ZERO;
    unique case (paddr)
      CONFIG_OFFSET: begin
        read_next = config_reg;
      end
      PRODUCT_LO_OFFSET: begin
        read_next = product[31:0];
      end
      PRODUCT_HI_OFFSET: begin
        read_next = {28'h0000000, product[35:32]};
      end
      CHAIN_OUT_OFFSET: begin
        read_next = {14'h0000, chain_operand_out};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel && !pready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= READ_ZERO;
      pslverr_reg <= 1'b0;
    end else if (psel && !pready_reg) begin
      prdata_reg <= (!pwrite && addr_hit) ? read_next : READ_ZERO;
      pslverr_reg <= !addr_hit;
    end else begin
      prdata_reg <= READ_ZERO;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= CONFIG_RESET;
    end else if (psel && penable && pready_reg && pwrite && paddr == CONFIG_OFFSET) begin
      config_reg <= pwdata & CONFIG_MASK; // RULE_17 RULE_21
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule
`default_nettype wire

// >>> verif/fabric_model.sv
// Neighbour multiplier below this one; its chain output feeds our chain input.
// Assumes the bench drives its shift enable and data on pclk.
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shift_en,
  input wire logic [17:0] din,
  output logic [17:0] chain_out
);
  // Operands come from fabric only; no wide neighbour memory shares their bits
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) chain_out <= 18'h00000;
    else if (shift_en) chain_out <= din;
endmodule
`default_nettype wire

// >>> verif/signed_mult18_pipelined_monitor.sv
// Checker for the multiplier datapath and chain output.
// Assumes top-level ports only; tracks config from APB writes.
`timescale 1ns/1ps
`default_nettype none
module mult_monitor
  import mult_pkg::*;
(
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [17:0] first_operand, second_operand, chain_operand_in, chain_operand_out,
  input wire logic first_operand_clock_enable, first_operand_sync_reset,
  input wire logic second_operand_clock_enable, second_operand_sync_reset,
  input wire logic product_clock_enable, product_sync_reset,
  input wire logic [35:0] product
);
  logic [31:0] cfg;
  wire cw = psel & penable & pready & pwrite & (paddr == CONFIG_OFFSET);
  wire [17:0] bs = cfg[3] ? chain_operand_in : second_operand;
  wire [35:0] m = $signed(first_operand) * $signed(bs);
  wire ra = first_operand_sync_reset ^ cfg[10];
  wire ca = first_operand_clock_enable ^ cfg[9];
  wire rb = second_operand_sync_reset ^ cfg[12];
  wire cb = second_operand_clock_enable ^ cfg[11];
  wire rp = product_sync_reset ^ cfg[14];
  wire cp = product_clock_enable ^ cfg[13];
  wire [2:0] r = cfg[2:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg <= CONFIG_RESET;
    else if (cw) cfg <= pwdata & CONFIG_MASK;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  comb_product_a: assert property (r == 3'h0 |-> product == m) else $error("p comb");
  product_clear_a: assert property (r[2] && rp && !cw |=> product == '0) else $error("p clr");
  product_hold_a: assert property (r[2] && !rp && !cp && !cw |=> $stable(product))
    else $error("p hold");
  product_load_a: assert property (r == 3'h4 && !rp && cp && !cw |=> product == $past(m))
    else $error("p load");
  chain_comb_a: assert property (!r[1] |-> chain_operand_out == bs) else $error("c comb");
  chain_clear_a: assert property (r[1] && rb && !cw |=> chain_operand_out == '0)
    else $error("c clr");
  chain_load_a: assert property (r[1] && !rb && cb && !cw |=> chain_operand_out == $past(bs))
    else $error("c load");
  first_clear_a: assert property (r == 3'h1 && ra && !cw |=> product == '0) else $error("a clr");
  first_load_a: assert property (r == 3'h1 && !ra && ca && !cw
    |=> $signed(product) == $signed($past(first_operand)) * $signed(bs)) else $error("a ld");
  cover property (r == 3'h7 && cp);
  cover property (cfg[3] && r[1] && cb);
  cover property (cw);
endmodule
bind signed_mult18_pipelined mult_monitor u_mult_monitor (.*);
`default_nettype wire

// >>> verif/signed_mult18_pipelined_tb.sv
// Random bench for the multiplier: config sweep, random operands and controls.
// Assumes the checker is bound to the design; reference model lives here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module signed_mult18_pipelined_tb;
  import mult_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sh = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cfg = 0, d;
  logic [17:0] fo = 0, so = 0, ci, co, ar = 0, br = 0, dn = 0;
  logic [5:0] ctl = 0;
  logic [35:0] p, pr = 0;
  int num_errors = 0, n_compared = 0, cyc = 0;
  wire [5:0] t = ctl ^ cfg[14:9];
  wire [17:0] bs = cfg[3] ? ci : so;
  wire [17:0] am = cfg[0] ? ar : fo;
  wire [17:0] bm = cfg[1] ? br : bs;
  wire [35:0] m = $signed(am) * $signed(bm);
  wire [35:0] exp_p = cfg[2] ? pr : m;
  signed_mult18_pipelined u_signed_mult18_pipelined (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .first_operand(fo), .second_operand(so),
    .chain_operand_in(ci), .first_operand_clock_enable(ctl[0]), .first_operand_sync_reset(ctl[1]),
    .second_operand_clock_enable(ctl[2]), .second_operand_sync_reset(ctl[3]),
    .product_clock_enable(ctl[4]), .product_sync_reset(ctl[5]), .product(p),
    .chain_operand_out(co));
  fabric_model u_fabric_model (.pclk, .presetn, .shift_en(sh), .din(dn), .chain_out(ci));
  always #5 pclk = ~pclk;
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      ar <= '0; br <= '0; pr <= '0;
    end else begin
      ar <= t[1] ? '0 : t[0] ? fo : ar;
      br <= t[3] ? '0 : t[2] ? bs : br;
      pr <= t[5] ? '0 : t[4] ? m : pr;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
        num_errors++;
        final_report();
      end
    end
  always @(negedge pclk) if (presetn) begin
    `CHK("product", (cfg[2] ? pr : m), p)
    `CHK("chain_out", bm, co)
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw,
                     input logic [31:0] er, input logic ee);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= dw;
    @(posedge pclk) penable <= 1'b1;
    // Read data is captured at the setup edge, so expect the value seen there
    if (a == PRODUCT_LO_OFFSET) er = exp_p[31:0];
    if (a == PRODUCT_HI_OFFSET) er = {28'h0000000, exp_p[35:32]};
    if (a == CHAIN_OUT_OFFSET) er = {14'h0000, bm};
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK("pslverr", ee, pslverr)
    if (!w) `CHK("prdata", er, prdata)
    psel <= 1'b0; penable <= 1'b0;
    if (w && a == CONFIG_OFFSET) cfg <= dw & CONFIG_MASK;
    @(posedge pclk);
  endtask
  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hC738));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, CONFIG_OFFSET, 0, CONFIG_RESET, 0);
    apb(1, 8'h10, 32'hFFFFFFFF, 0, 1);
    apb(0, 8'h10, 0, READ_ZERO, 1);
    apb(1, PRODUCT_LO_OFFSET, 32'hFFFFFFFF, 0, 0);
    for (int i = 0; i < 48; i++) begin
      d = i < 16 ? i : $urandom & CONFIG_MASK;
      apb(1, CONFIG_OFFSET, d, 0, 0);
      apb(0, CONFIG_OFFSET, 0, d, 0);
      repeat (20) begin
        fo <= $urandom % 5 == 0 ? 18'h20000 : 18'($urandom);
        so <= 18'($urandom); dn <= 18'($urandom); sh <= 1'($urandom); ctl <= 6'($urandom);
        @(posedge pclk);
      end
      apb(0, PRODUCT_LO_OFFSET, 0, 0, 0);
      apb(0, PRODUCT_HI_OFFSET, 0, 0, 0);
      apb(0, CHAIN_OUT_OFFSET, 0, 0, 0);
    end
    final_report();
  end
endmodule
`default_nettype wire
